// ---- core/frl_cfg.svh ----
// constants of the fan ramp limiter: offsets, fields, reset values, timing
`ifndef FRL_CFG_SVH
`define FRL_CFG_SVH
// register indices as printed; byte address is four times the index
`define FRL_IDX_CTRL1     32'h0000_0062
`define FRL_IDX_CTRL2     32'h0000_0063
// registers of our own, byte addresses
`define FRL_ADDR_CRIT     32'h0000_0190
`define FRL_ADDR_MINDUTY  32'h0000_0194
`define FRL_ADDR_STATUS   32'h0000_0198
// field positions
`define FRL_EN1_BIT       3
`define FRL_EN2_BIT       7
`define FRL_EN3_BIT       3
`define FRL_RATE1_LO      0
`define FRL_RATE2_LO      4
`define FRL_RATE3_LO      0
`define FRL_KEEPMIN_LO    5
`define FRL_HOT_BIT       24
// reset values
`define FRL_CTRL_RST      8'h00
`define FRL_CRIT_RST      24'h64_64_64
`define FRL_MIN_RST       24'h00_00_00
`define FRL_DUTY_RST      8'h00
// duty and timing
`define FRL_FULL_DUTY     8'hff
`define FRL_PWM_SLOTS     255
`define FRL_THERM_HYST    9'h004
`define FRL_RAMP_FULL_US  35000000
`define FRL_CLK_MHZ       100
`define FRL_SLOT_CYCLES   16
`define FRL_HTRANS_NONSEQ 2'h2
`define FRL_HSIZE_WORD    3'h2
`endif

// ---- core/frl_pkg.sv ----
// types of the fan ramp limiter
package frl_pkg;
    // bus data-phase state; one bit flips idle -> read, two bits flip idle -> write
    typedef enum logic [1:0] {
        FRL_IDLE  = 2'b00,
        FRL_READ  = 2'b01,
        FRL_WRITE = 2'b11
    } frl_bus_e;

    // complete register state of the block
    typedef struct packed {
        frl_bus_e    bus;
        logic [31:0] addr;
        logic [7:0]  ctrl1;
        logic [7:0]  ctrl2;
        logic [23:0] crit;
        logic [23:0] minDuty;
        logic [23:0] duty;
        logic [23:0] tick;
        logic [15:0] slotDiv;
        logic [7:0]  slotPos;
        logic        hot;
        logic [2:0]  pwm;
        logic [31:0] rdata;
    } frl_state_s;
endpackage : frl_pkg

// ---- core/frl_ramp_limiter.sv ----
// fan ramp limiter: three ramp-limited pwm fan drives behind an ahb-lite slave
//
// How it works
// - output 1 ramps only while bit 3 of register 0x62 is set.
// - output 2 ramps only while bit 7 of register 0x63 is set.
// - output 3 ramps only while bit 3 of register 0x63 is set.
// - the pwm period holds 255 slots; one slot is the smallest duty step.
// - bits 2:0 of 0x62 pick output 1 step: 1,2,3,5,8,12,24,48 slots.
// - bits 2:0 of 0x63 pick output 3 step with the same codes.
// - bits 6:4 of 0x63 pick output 2 step with the same codes.
// - target above stored duty raises the stored duty by the step.
// - target below stored duty lowers the stored duty by the step.
// - each stepped value is kept as the duty for the next compare.
// - step interval makes a one-slot full ramp take about 35 seconds.
// - any temperature above its limit drives all fans full until all are more than 4 below.
// - bits 7:5 of 0x62 choose off or minimum duty below the low threshold.
//
// register map, byte addresses on the ahb side
//   0x188: first ramp control; keep-min bits 7:5, out1 enable bit 3, out1 rate 2:0
//   0x18c: second ramp control; out2 enable bit 7, out2 rate 6:4,
//          out3 enable bit 3, out3 rate 2:0
//   0x190: critical limits, remote2 23:16, local 15:8, remote1 7:0
//   0x194: minimum duty per output, out3 23:16, out2 15:8, out1 7:0
//   0x198: status, read only; hot flag bit 24, stored duties below it
//   other addresses read zero and ignore writes
//
// bus timing
//   zero wait states; hreadyout is tied high and hresp is always okay
//   read data is staged at the address phase and stands until the next read
//   a write lands at the edge that ends its data phase
//   a read issued in the data phase of a write to the same register
//   returns the old value; a non-pipelined master never sees this
//
// ramp timing
//   one tick every RAMP_CYCLES clocks, free running from reset
//   a ramping output moves at most one step per tick, never past its target
//   a non-ramping output copies its target on every clock
//   the stored duty shows in status one edge after it changes
//   the pin follows one edge after the stored duty
//   switching ramping off lets the duty jump straight to the target;
//   switching it on starts from whatever duty was stored at that moment
//
// pwm timing
//   the slot position advances every SLOT_CYCLES clocks and wraps after 254
//   a pin is high while the slot position is below its duty
//   full duty holds the pin high for the whole period, with no low slot
//
// thermal override
//   any channel above its limit sets the hot flag on the next edge
//   the flag clears only once every channel sits more than 4 below its limit
//   while hot, every pin is forced high; stored duties keep ramping underneath,
//   so the fans resume from the ramped value, not from full, when it clears
//
// limitations
//   the temperature loop, spin-up and tachometer logic live elsewhere
//   hsize is accepted but ignored; only whole-word transfers are expected
//   the low-temperature choice feeds the ramp like any other target
//   no interrupt; the hot flag is only visible through status
//   tick and slot counters hold 24 and 16 bits, checked at elaboration
`timescale 1ns/1ps
`include "frl_cfg.svh"
module frl_ramp_limiter
    import frl_pkg::*;
#(
    parameter int RAMP_CYCLES = int'(longint'(`FRL_RAMP_FULL_US / `FRL_PWM_SLOTS)
                                     * `FRL_CLK_MHZ),
    parameter int SLOT_CYCLES = `FRL_SLOT_CYCLES
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // duty targets from the temperature loop, same clock
    input  wire logic [7:0]  targetDuty1,
    input  wire logic [7:0]  targetDuty2,
    input  wire logic [7:0]  targetDuty3,
    input  wire logic [2:0]  belowMinTemp,
    // channel temperatures, same clock
    input  wire logic [7:0]  tempRemote1,
    input  wire logic [7:0]  tempLocal,
    input  wire logic [7:0]  tempRemote2,
    // fan drive pins
    output logic             fanDriveOut1,
    output logic             fanDriveOut2,
    output logic             fanDriveOut3
);

    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks

    // counters in the state struct are 24 and 16 bits wide
    if (RAMP_CYCLES < 1 || RAMP_CYCLES > 24'hff_ffff) begin : g_bad_ramp
        $error("RAMP_CYCLES out of range");
    end
    if (SLOT_CYCLES < 1 || SLOT_CYCLES > 16'hffff) begin : g_bad_slot
        $error("SLOT_CYCLES out of range");
    end

    localparam logic [23:0] RAMP_LAST = 24'(RAMP_CYCLES - 1);
    localparam logic [15:0] SLOT_LAST = 16'(SLOT_CYCLES - 1);
    localparam logic [7:0]  POS_LAST  = 8'(`FRL_PWM_SLOTS - 1);
    localparam logic [31:0] ADDR_CTRL1 = `FRL_IDX_CTRL1 << 2;
    localparam logic [31:0] ADDR_CTRL2 = `FRL_IDX_CTRL2 << 2;

    ////////////////////////////////////////////////////////////////////////////
    // functions

    // ramp code to slot count
    function automatic logic [7:0] stepOf(input logic [2:0] code);
        case (code)
            3'h0: stepOf = 8'h01;
            3'h1: stepOf = 8'h02;
            3'h2: stepOf = 8'h03;
            3'h3: stepOf = 8'h05;
            3'h4: stepOf = 8'h08;
            3'h5: stepOf = 8'h0c;
            3'h6: stepOf = 8'h18;
            default: stepOf = 8'h30;
        endcase
    endfunction : stepOf

    // one step of the stored duty toward the target, clamped at the target
    function automatic logic [7:0] rampOf(input logic [7:0] prev,
                                          input logic [7:0] tgt,
                                          input logic [7:0] step);
        logic [7:0] gap;
        gap = 8'h00;
        rampOf = prev;
        if (tgt > prev) begin
            gap = tgt - prev;
            rampOf = (gap <= step) ? tgt : 8'(prev + step);
        end else if (tgt < prev) begin
            gap = prev - tgt;
            rampOf = (gap <= step) ? tgt : 8'(prev - step);
        end
    endfunction : rampOf

    // register read decode, zero on unmapped addresses
    function automatic logic [31:0] readOf(input logic [31:0] a,
                                           input frl_state_s s);
        case (a)
            ADDR_CTRL1:        readOf = {24'h00_0000, s.ctrl1};
            ADDR_CTRL2:        readOf = {24'h00_0000, s.ctrl2};
            `FRL_ADDR_CRIT:    readOf = {8'h00, s.crit};
            `FRL_ADDR_MINDUTY: readOf = {8'h00, s.minDuty};
            `FRL_ADDR_STATUS:  readOf = {7'h00, s.hot, s.duty};
            default:           readOf = 32'h0000_0000;
        endcase
    endfunction : readOf

    ////////////////////////////////////////////////////////////////////////////
    // state

    frl_state_s st;
    frl_state_s next_st;

    logic [23:0] target;
    logic [23:0] temps;
    logic [2:0]  rampEn;
    logic [8:0]  rateCodes;

    // gather per-output inputs so the loops below can index them
    assign target = {targetDuty3, targetDuty2, targetDuty1};
    assign temps  = {tempRemote2, tempLocal, tempRemote1};
    assign rampEn = {st.ctrl2[`FRL_EN3_BIT], st.ctrl2[`FRL_EN2_BIT],
                     st.ctrl1[`FRL_EN1_BIT]};
    assign rateCodes = {st.ctrl2[`FRL_RATE3_LO +: 3], st.ctrl2[`FRL_RATE2_LO +: 3],
                        st.ctrl1[`FRL_RATE1_LO +: 3]};

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic

    // bus, ramp, thermal override and pwm slot counter in one pass
    always_comb begin
        logic [7:0] tgt;
        logic       tickDone;
        logic       anyOver;
        logic       allClear;
        tgt      = 8'h00;
        tickDone = 1'b0;
        anyOver  = 1'b0;
        allClear = 1'b1;
        next_st  = st;

        // ahb data phase: writes land here, reads were staged at address phase
        if (st.bus == FRL_WRITE) begin
            case (st.addr)
                ADDR_CTRL1:        next_st.ctrl1   = hwdata[7:0];
                ADDR_CTRL2:        next_st.ctrl2   = hwdata[7:0];
                `FRL_ADDR_CRIT:    next_st.crit    = hwdata[23:0];
                `FRL_ADDR_MINDUTY: next_st.minDuty = hwdata[23:0];
                default:           next_st.ctrl1   = st.ctrl1;
            endcase
        end
        next_st.bus = FRL_IDLE;
        if (hsel && hready && htrans == `FRL_HTRANS_NONSEQ) begin
            next_st.addr = haddr;
            next_st.bus  = hwrite ? FRL_WRITE : FRL_READ;
            if (!hwrite) begin
                next_st.rdata = readOf(haddr, st);
            end
        end

        // update interval: one tick per full-scale slot time
        tickDone = (st.tick == RAMP_LAST);
        next_st.tick = tickDone ? 24'h00_0000 : 24'(st.tick + 1'b1);

        // per output: low-temperature choice, then ramp or follow
        for (int i = 0; i < 3; i++) begin
            if (belowMinTemp[i]) begin
                tgt = st.ctrl1[`FRL_KEEPMIN_LO + i] ? st.minDuty[i*8 +: 8]
                                                     : 8'h00;
            end else begin
                tgt = target[i*8 +: 8];
            end
            if (!rampEn[i]) begin
                next_st.duty[i*8 +: 8] = tgt;
            end else if (tickDone) begin
                next_st.duty[i*8 +: 8] = rampOf(st.duty[i*8 +: 8], tgt,
                                                stepOf(rateCodes[i*3 +: 3]));
            end
        end

        // critical temperature with hysteresis, over all channels
        for (int i = 0; i < 3; i++) begin
            if (temps[i*8 +: 8] > st.crit[i*8 +: 8]) begin
                anyOver = 1'b1;
            end
            if (9'({1'b0, temps[i*8 +: 8]}) + `FRL_THERM_HYST >= {1'b0, st.crit[i*8 +: 8]}) begin
                allClear = 1'b0;
            end
        end
        if (anyOver) begin
            next_st.hot = 1'b1;
        end else if (allClear) begin
            next_st.hot = 1'b0;
        end

        // pwm slot position, 255 slots per period
        if (st.slotDiv == SLOT_LAST) begin
            next_st.slotDiv = 16'h0000;
            next_st.slotPos = (st.slotPos == POS_LAST) ? 8'h00
                                                       : 8'(st.slotPos + 1'b1);
        end else begin
            next_st.slotDiv = 16'(st.slotDiv + 1'b1);
        end

        // pin is high for duty slots; full duty stays high all period
        for (int i = 0; i < 3; i++) begin
            if (st.hot) begin
                next_st.pwm[i] = 1'b1;
            end else begin
                next_st.pwm[i] = (st.duty[i*8 +: 8] == `FRL_FULL_DUTY) ||
                                 (st.slotPos < st.duty[i*8 +: 8]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    // ramp state is cleared on reset so fans start from standstill
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st.bus     <= FRL_IDLE;
            st.addr    <= 32'h0000_0000;
            st.ctrl1   <= `FRL_CTRL_RST;
            st.ctrl2   <= `FRL_CTRL_RST;
            st.crit    <= `FRL_CRIT_RST;
            st.minDuty <= `FRL_MIN_RST;
            st.duty    <= {3{`FRL_DUTY_RST}};
            st.tick    <= 24'h00_0000;
            st.slotDiv <= 16'h0000;
            st.slotPos <= 8'h00;
            st.hot     <= 1'b0;
            st.pwm     <= 3'h0;
            st.rdata   <= 32'h0000_0000;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // zero wait states, always okay; read data stands through the data phase
    assign hreadyout    = 1'b1;
    assign hresp        = 1'b0;
    assign hrdata       = st.rdata;
    assign fanDriveOut1 = st.pwm[0];
    assign fanDriveOut2 = st.pwm[1];
    assign fanDriveOut3 = st.pwm[2];

endmodule : frl_ramp_limiter

// ---- tb/frl_ramp_limiter_props.sv ----
// checker of the fan ramp limiter ports
`timescale 1ns/1ps
module frl_ramp_limiter_props (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rstn,
    // ahb-lite slave side
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    // targets and temperatures
    input wire logic [7:0]  targetDuty1,
    input wire logic [7:0]  targetDuty2,
    input wire logic [2:0]  belowMinTemp,
    input wire logic [7:0]  tempRemote1,
    input wire logic [7:0]  tempLocal,
    input wire logic [7:0]  tempRemote2,
    // fan pins
    input wire logic        fanDriveOut1,
    input wire logic        fanDriveOut2,
    input wire logic        fanDriveOut3
);
    logic [7:0]  m1, m2;
    logic [23:0] crit;
    logic [31:0] wrAddr;
    logic        wrPend, hotM;
    wire         take = hsel && hready && htrans == 2'h2;
    wire         anyHot = tempRemote1 > crit[7:0] || tempLocal > crit[15:8]
                          || tempRemote2 > crit[23:16];
    wire         allCool = {1'b0, tempRemote1} + 9'h4 < {1'b0, crit[7:0]}
                           && {1'b0, tempLocal} + 9'h4 < {1'b0, crit[15:8]}
                           && {1'b0, tempRemote2} + 9'h4 < {1'b0, crit[23:16]};
    // register mirror; writes land at the end of the data phase, like the slave's
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            {m1, m2, wrPend, hotM, wrAddr} <= '0;
            crit <= 24'h646464;
        end else begin
            wrPend <= take && hwrite;
            wrAddr <= haddr;
            if (wrPend && wrAddr == 32'h188) m1 <= hwdata[7:0];
            if (wrPend && wrAddr == 32'h18c) m2 <= hwdata[7:0];
            if (wrPend && wrAddr == 32'h190) crit <= hwdata[23:0];
            if (anyHot) hotM <= 1'b1;
            else if (allCool) hotM <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence takeRd(logic [31:0] a);
        take && !hwrite && haddr == a;
    endsequence
    sequence fullOff1;
        !m1[3] && targetDuty1 == 8'hff && !belowMinTemp[0];
    endsequence
    sequence fullOff2;
        !m2[7] && targetDuty2 == 8'hff && !belowMinTemp[1];
    endsequence
    AST_READY: assert property (hreadyout) else $error("hreadyout low");
    AST_OKAY: assert property (!hresp) else $error("error response");
    AST_RD_CTRL1: assert property (takeRd(32'h188) |=> hrdata == {24'h0, $past(m1)})
        else $error("ctrl first readback");
    AST_RD_CTRL2: assert property (takeRd(32'h18c) |=> hrdata == {24'h0, $past(m2)})
        else $error("ctrl second readback");
    AST_RD_CRIT: assert property (takeRd(32'h190) |=> hrdata == {8'h0, $past(crit)})
        else $error("limit readback");
    AST_RD_HOLE: assert property (takeRd(32'h100) |=> hrdata == 32'h0)
        else $error("unmapped read");
    AST_HOLD: assert property (!(take && !hwrite) |=> $stable(hrdata))
        else $error("read data moved");
    AST_HOT: assert property (hotM [*2] |-> {fanDriveOut1, fanDriveOut2, fanDriveOut3} == 3'h7)
        else $error("fans not full while hot");
    AST_FULL1: assert property (fullOff1 [*3] |-> fanDriveOut1)
        else $error("out1 not full");
    AST_FULL2: assert property (fullOff2 [*3] |-> fanDriveOut2)
        else $error("out2 not full");
endmodule : frl_ramp_limiter_props

bind frl_ramp_limiter frl_ramp_limiter_props u_props (
    .sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .targetDuty1(targetDuty1), .targetDuty2(targetDuty2),
    .belowMinTemp(belowMinTemp), .tempRemote1(tempRemote1), .tempLocal(tempLocal),
    .tempRemote2(tempRemote2), .fanDriveOut1(fanDriveOut1), .fanDriveOut2(fanDriveOut2),
    .fanDriveOut3(fanDriveOut3));

// ---- tb/frl_fan_model.sv ----
// fan model: integrates its drive pin over one pwm period
`timescale 1ns/1ps
module frl_fan_model #(
    parameter int PERIOD = 255
) (
    // clock and drive pin
    input wire logic sys_clk,
    input wire logic drive,
    // high slots seen over the last period
    output logic [7:0] seenDuty
);
    logic [PERIOD-1:0] hist = '0;
    // any window of one period holds exactly duty high slots
    always @(posedge sys_clk) hist <= {hist[PERIOD-2:0], drive};
    assign seenDuty = 8'($countones(hist));
endmodule : frl_fan_model

// ---- tb/frl_ramp_limiter_bench.sv ----
// self-checking bench of the fan ramp limiter
`timescale 1ns/1ps
module frl_ramp_limiter_bench;
    localparam logic [7:0] STEPS [8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0c, 8'h18, 8'h30};
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [2:0]  belowMinTemp = 3'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] rdVal, lim, hrdata;
    logic [7:0]  tgt [3] = '{8'h00, 8'h00, 8'h00};
    logic [7:0]  temp [3] = '{8'h00, 8'h00, 8'h00};
    logic [7:0]  seen [3];
    logic [7:0]  st, nt, v;
    logic [2:0]  fan, c;
    logic        hreadyout, hresp;
    int          miscompares = 0;
    int          checkCount = 0;
    int          seed, n, o;
    time         tStep;
    localparam int RAMP = 20;

    frl_ramp_limiter #(.RAMP_CYCLES(RAMP), .SLOT_CYCLES(1)) dut (
        .sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .targetDuty1(tgt[0]), .targetDuty2(tgt[1]), .targetDuty3(tgt[2]),
        .belowMinTemp(belowMinTemp), .tempRemote1(temp[0]), .tempLocal(temp[1]),
        .tempRemote2(temp[2]), .fanDriveOut1(fan[0]), .fanDriveOut2(fan[1]),
        .fanDriveOut3(fan[2]));
    for (genvar i = 0; i < 3; i++) begin : g_fan
        frl_fan_model u_fan (.sys_clk(sys_clk), .drive(fan[i]), .seenDuty(seen[i]));
    end

    always #5 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        if (miscompares == 0 && checkCount > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // bounded wait for hready; a hang ends the run as a mismatch
    task automatic waitRdy;
        int k;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 64);
        if (k >= 64) begin
            miscompares++;
            give_verdict();
        end
    endtask : waitRdy
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        waitRdy();
        htrans <= 2'h0;
        hwdata <= d;
        waitRdy();
        rdVal = hrdata;
    endtask : bus
    task automatic rdChk(input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rdVal, e);
    endtask : rdChk
    // one ramp step toward the target, clamped so it never overshoots
    function automatic logic [7:0] expStep(logic [7:0] d, logic [7:0] t, logic [2:0] k);
        if (t > d) return (t - d < STEPS[k]) ? t : d + STEPS[k];
        if (t < d) return (d - t < STEPS[k]) ? t : d - STEPS[k];
        return d;
    endfunction : expStep
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h7194;
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        rdChk(32'h188, 32'h0);
        rdChk(32'h18c, 32'h0);
        rdChk(32'h190, 32'h646464);
        rdChk(32'h100, 32'h0);
        bus(1'b1, 32'h188, 32'hffff_ff07);
        rdChk(32'h188, 32'h07);
        // every code on every output; no spin-up exists, ramping runs with it off
        for (int k = 0; k < 24; k++) begin
            o = k % 3;
            c = 3'(k / 3);
            st = 8'($random(seed));
            nt = (c == 3'h7) ? st ^ 8'h40 : 8'($random(seed));
            bus(1'b1, 32'h188, 32'h0);
            bus(1'b1, 32'h18c, 32'h0);
            tgt[o] <= st;
            repeat (3) @(posedge sys_clk);
            bus(1'b1, o == 0 ? 32'h188 : 32'h18c,
                o == 1 ? {24'h0, 1'b1, c, 4'h0} : {28'h0, 1'b1, c});
            tgt[o] <= nt;
            v = st;
            for (int s = 0; s < 2; s++) begin
                n = 0;
                do begin
                    bus(1'b0, 32'h198, 32'h0);
                    n++;
                end while (rdVal[8*o +: 8] === v && v !== nt && n < 40);
                chk(rdVal[8*o +: 8], expStep(v, nt, c));
                // polls run every two clocks, so two steps show one interval apart
                if (s == 1 && v !== nt) begin
                    chk(32'(($time - tStep) / 10), RAMP);
                end
                tStep = $time;
                v = expStep(v, nt, c);
            end
        end
        // ramping off: duty follows target and the fan sees it slot for slot
        bus(1'b1, 32'h188, 32'h0);
        bus(1'b1, 32'h18c, 32'h0);
        tgt <= '{8'hff, 8'hff, 8'($random(seed))};
        repeat (300) @(posedge sys_clk);
        for (int i = 0; i < 3; i++) chk(seen[i], tgt[i]);
        lim = 32'($random(seed)) & 32'h00ff_ffff;
        bus(1'b1, 32'h194, lim);
        bus(1'b1, 32'h188, 32'he0);
        belowMinTemp <= 3'h7;
        repeat (3) @(posedge sys_clk);
        rdChk(32'h198, lim);
        bus(1'b1, 32'h188, 32'h0);
        repeat (2) @(posedge sys_clk);
        rdChk(32'h198, 32'h0);
        lim = (32'($random(seed)) & 32'h7f7f7f) | 32'h101010;
        bus(1'b1, 32'h190, lim);
        temp[1] <= lim[15:8] + 8'h1;
        repeat (4) @(posedge sys_clk);
        chk(32'(fan), 32'h7);
        rdChk(32'h198, 32'h0100_0000);
        temp[1] <= lim[15:8] - 8'h4;
        repeat (4) @(posedge sys_clk);
        chk(32'(fan), 32'h7);
        temp[1] <= lim[15:8] - 8'h5;
        repeat (4) @(posedge sys_clk);
        chk(32'(fan), 32'h0);
        give_verdict();
    end
endmodule : frl_ramp_limiter_bench
